// file: rtl/uhlp_regs.vh
`ifndef UHLP_REGS_VH
`define UHLP_REGS_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define UHLP_ADDR_W          8
`define UHLP_OFF_BULK_HEAD   8'h28
`define UHLP_OFF_BULK_CUR    8'h2c
`define UHLP_OFF_DONE_QUEUE  8'h30
`define UHLP_OFF_FRAME_INT   8'h34
`define UHLP_OFF_ACC_STAT    8'h40

// ----------------------------------------------------------------------
// pointer layout
// ----------------------------------------------------------------------
`define UHLP_DATA_W          32
`define UHLP_PTR_ZERO_BITS   4
`define UHLP_PTR_RESET       32'h0000_0000

// ----------------------------------------------------------------------
// frame interval layout
// ----------------------------------------------------------------------
`define UHLP_FI_MSB          13
`define UHLP_FI_LSB          0
`define UHLP_FI_W            14
`define UHLP_FI_RESET        14'h2ebf
`define UHLP_RSV_MSB         15
`define UHLP_RSV_LSB         14
`define UHLP_RSV_W           2
`define UHLP_RSV_RESET       2'h0
`define UHLP_MPS_MSB         30
`define UHLP_MPS_LSB         16
`define UHLP_MPS_W           15
`define UHLP_MPS_RESET       15'h0000
`define UHLP_TOG_BIT         31
`define UHLP_TOG_RESET       1'h0

// ----------------------------------------------------------------------
// access status layout
// ----------------------------------------------------------------------
`define UHLP_STAT_W          2
`define UHLP_STAT_RO_WRITE   0
`define UHLP_STAT_UNMAPPED   1
`define UHLP_STAT_RESET      2'h0

`endif

// file: rtl/uhlp_ptr_reg.v
`timescale 1ns/1ps
`default_nettype none
`include "uhlp_regs.vh"

module uhlp_ptr_reg #(
   parameter                     WIDTH       = `UHLP_DATA_W,
   parameter                     ZERO_BITS   = `UHLP_PTR_ZERO_BITS,
   parameter [0:0]               SW_WRITE    = 1'b1,
   parameter [0:0]               HW_WRITE    = 1'b1,
   parameter [WIDTH-1:0]         RESET_VALUE = `UHLP_PTR_RESET
) (
   // clock and reset
   input  wire                   clk,
   input  wire                   rst_n,
   // software write port
   input  wire                   sw_we,
   input  wire [WIDTH-1:0]       sw_wdata,
   // controller write port
   input  wire                   hw_we,
   input  wire [WIDTH-1:0]       hw_wdata,
   // stored pointer
   output reg  [WIDTH-1:0]       value
);

   // ----------------------------------------------------------------------
   // pointer storage, low bits held at zero
   // ----------------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         value <= RESET_VALUE;
      end else if (HW_WRITE && hw_we) begin
         value <= {hw_wdata[WIDTH-1:ZERO_BITS], {ZERO_BITS{1'b0}}}; // RL2 RL3 RL4 RL5
      end else if (SW_WRITE && sw_we) begin
         value <= {sw_wdata[WIDTH-1:ZERO_BITS], {ZERO_BITS{1'b0}}}; // RL1 RL2 RL5
      end
   end

endmodule

`default_nettype wire

// file: rtl/uhlp_frame_reg.v
`timescale 1ns/1ps
`default_nettype none
`include "uhlp_regs.vh"

module uhlp_frame_reg (
   // clock and reset
   input  wire                   clk,
   input  wire                   rst_n,
   // software write port
   input  wire                   sw_we,
   input  wire [`UHLP_DATA_W-1:0] sw_wdata,
   // fields
   output reg  [`UHLP_FI_W-1:0]  frame_length_bits,
   output reg  [`UHLP_MPS_W-1:0] max_packet_bits,
   output reg  [`UHLP_RSV_W-1:0] reserved_bits,
   output reg                    interval_toggle,
   output reg                    load_pulse
);

   // ----------------------------------------------------------------------
   // field storage; toggle flips on every load of the interval
   // ----------------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_length_bits <= `UHLP_FI_RESET; // RL9
         max_packet_bits   <= `UHLP_MPS_RESET; // RL9
         reserved_bits     <= `UHLP_RSV_RESET;
         interval_toggle   <= `UHLP_TOG_RESET; // RL9
         load_pulse        <= 1'b0;
      end else begin
         load_pulse <= sw_we;
         if (sw_we) begin
            frame_length_bits <= sw_wdata[`UHLP_FI_MSB:`UHLP_FI_LSB]; // RL8 RL9
            max_packet_bits   <= sw_wdata[`UHLP_MPS_MSB:`UHLP_MPS_LSB]; // RL8 RL9
            reserved_bits     <= sw_wdata[`UHLP_RSV_MSB:`UHLP_RSV_LSB];
            interval_toggle   <= ~interval_toggle; // RL6
         end
      end
   end

endmodule

`default_nettype wire

// file: rtl/uhlp_list_regs.v
// Function
// (RL1) bulk head: software writes, controller reads
// (RL2) bulk current: both sides write
// (RL3) done head: controller writes, software reads
// (RL4) done head at own offset, zero reset
// (RL5) pointer low four bits always zero
// (RL6) toggle inverts on each interval load
// (RL7) software writes zero to reserved bits
// (RL8) interval and packet-size fields as laid out
// (RL9) frame fields software-written, defined reset values
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "uhlp_regs.vh"

module uhlp_list_regs (
   // clock and reset
   input  wire                      clk,
   input  wire                      rst_n,
   // software register port
   input  wire [`UHLP_ADDR_W-1:0]   reg_addr,
   input  wire [`UHLP_DATA_W-1:0]   reg_wdata,
   input  wire                      reg_write,
   input  wire                      reg_read,
   output reg  [`UHLP_DATA_W-1:0]   reg_rdata,
   // controller logic write ports
   input  wire                      ctl_bulk_current_we,
   input  wire [`UHLP_DATA_W-1:0]   ctl_bulk_current_wdata,
   input  wire                      ctl_done_queue_we,
   input  wire [`UHLP_DATA_W-1:0]   ctl_done_queue_wdata,
   // controller logic view
   output wire [`UHLP_DATA_W-1:0]   bulk_head_addr,
   output wire [`UHLP_DATA_W-1:0]   bulk_current_addr,
   output wire [`UHLP_DATA_W-1:0]   done_queue_addr,
   output wire [`UHLP_FI_W-1:0]     frame_length_bits,
   output wire [`UHLP_MPS_W-1:0]    max_packet_bits,
   output wire                      interval_toggle,
   output wire                      frame_interval_loaded
);

   // ----------------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------------
   reg                              sel_head;
   reg                              sel_cur;
   reg                              sel_done;
   reg                              sel_frame;
   reg                              sel_stat;
   wire                             sel_any;
   wire [`UHLP_RSV_W-1:0]           reserved_bits;
   reg  [`UHLP_STAT_W-1:0]          acc_stat;
   reg  [`UHLP_STAT_W-1:0]          next_acc_stat;
   reg  [`UHLP_DATA_W-1:0]          next_rdata;

   always @* begin
      sel_head  = 1'b0;
      sel_cur   = 1'b0;
      sel_done  = 1'b0;
      sel_frame = 1'b0;
      sel_stat  = 1'b0;
      if (reg_addr == `UHLP_OFF_BULK_HEAD) begin
         sel_head = 1'b1;
      end else if (reg_addr == `UHLP_OFF_BULK_CUR) begin
         sel_cur = 1'b1;
      end else if (reg_addr == `UHLP_OFF_DONE_QUEUE) begin
         sel_done = 1'b1; // RL4
      end else if (reg_addr == `UHLP_OFF_FRAME_INT) begin
         sel_frame = 1'b1;
      end else if (reg_addr == `UHLP_OFF_ACC_STAT) begin
         sel_stat = 1'b1;
      end
   end

   assign sel_any = sel_head | sel_cur | sel_done | sel_frame | sel_stat;

   // ----------------------------------------------------------------------
   // pointer registers
   // ----------------------------------------------------------------------
   uhlp_ptr_reg #(
      .SW_WRITE    (1'b1),
      .HW_WRITE    (1'b0)
   ) u_bulk_head (
      .clk         (clk),
      .rst_n       (rst_n),
      .sw_we       (reg_write & sel_head), // RL1
      .sw_wdata    (reg_wdata),
      .hw_we       (1'b0),
      .hw_wdata    (`UHLP_PTR_RESET),
      .value       (bulk_head_addr)
   );

   uhlp_ptr_reg #(
      .SW_WRITE    (1'b1),
      .HW_WRITE    (1'b1)
   ) u_bulk_cur (
      .clk         (clk),
      .rst_n       (rst_n),
      .sw_we       (reg_write & sel_cur), // RL2
      .sw_wdata    (reg_wdata),
      .hw_we       (ctl_bulk_current_we), // RL2
      .hw_wdata    (ctl_bulk_current_wdata),
      .value       (bulk_current_addr)
   );

   uhlp_ptr_reg #(
      .SW_WRITE    (1'b0),
      .HW_WRITE    (1'b1)
   ) u_done_queue (
      .clk         (clk),
      .rst_n       (rst_n),
      .sw_we       (1'b0), // RL3
      .sw_wdata    (reg_wdata),
      .hw_we       (ctl_done_queue_we), // RL3
      .hw_wdata    (ctl_done_queue_wdata),
      .value       (done_queue_addr)
   );

   // ----------------------------------------------------------------------
   // frame interval register
   // ----------------------------------------------------------------------
   uhlp_frame_reg u_frame (
      .clk               (clk),
      .rst_n             (rst_n),
      .sw_we             (reg_write & sel_frame), // RL9
      .sw_wdata          (reg_wdata),
      .frame_length_bits (frame_length_bits),
      .max_packet_bits   (max_packet_bits),
      .reserved_bits     (reserved_bits),
      .interval_toggle   (interval_toggle),
      .load_pulse        (frame_interval_loaded)
   );

   // ----------------------------------------------------------------------
   // access status: sticky, write one to clear, set wins
   // ----------------------------------------------------------------------
   always @* begin
      next_acc_stat = acc_stat;
      if (reg_write && sel_stat) begin
         next_acc_stat = acc_stat & ~reg_wdata[`UHLP_STAT_W-1:0];
      end
      if (reg_write && sel_done) begin
         next_acc_stat[`UHLP_STAT_RO_WRITE] = 1'b1;
      end
      if ((reg_write || reg_read) && !sel_any) begin
         next_acc_stat[`UHLP_STAT_UNMAPPED] = 1'b1;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_stat <= `UHLP_STAT_RESET;
      end else begin
         acc_stat <= next_acc_stat;
      end
   end

   // ----------------------------------------------------------------------
   // read back, data one cycle after the strobe
   // ----------------------------------------------------------------------
   always @* begin
      next_rdata = {`UHLP_DATA_W{1'b0}};
      if (sel_head) begin
         next_rdata = bulk_head_addr; // RL1
      end else if (sel_cur) begin
         next_rdata = bulk_current_addr; // RL2
      end else if (sel_done) begin
         next_rdata = done_queue_addr; // RL3 RL4
      end else if (sel_frame) begin
         next_rdata[`UHLP_TOG_BIT]                = interval_toggle; // RL6
         next_rdata[`UHLP_MPS_MSB:`UHLP_MPS_LSB] = max_packet_bits; // RL8
         next_rdata[`UHLP_RSV_MSB:`UHLP_RSV_LSB] = reserved_bits;
         next_rdata[`UHLP_FI_MSB:`UHLP_FI_LSB]   = frame_length_bits; // RL8
      end else if (sel_stat) begin
         next_rdata[`UHLP_STAT_W-1:0] = acc_stat;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= `UHLP_PTR_RESET;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= `UHLP_PTR_RESET;
      end
   end

endmodule

`default_nettype wire

// file: verif/uhlp_list_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module uhlp_list_regs_checker (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // software port
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [31:0] reg_rdata,
   // controller ports
   input wire logic        ctl_bulk_current_we,
   input wire logic [31:0] ctl_bulk_current_wdata,
   input wire logic        ctl_done_queue_we,
   input wire logic [31:0] ctl_done_queue_wdata,
   input wire logic [31:0] bulk_head_addr,
   input wire logic [31:0] bulk_current_addr,
   input wire logic [31:0] done_queue_addr,
   input wire logic [13:0] frame_length_bits,
   input wire logic [14:0] max_packet_bits,
   input wire logic        interval_toggle,
   input wire logic        frame_interval_loaded
);
   // ------------------------------------------------------------
   // register rules
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire wr_frame = reg_write && reg_addr == 8'h34;
   head_sw_write_a:
   assert property (reg_write && reg_addr == 8'h28 |=> bulk_head_addr == {$past(reg_wdata[31:4]), 4'h0})
      else $error("bulk head write lost");
   cur_sw_write_a:
   assert property (reg_write && reg_addr == 8'h2c && !ctl_bulk_current_we
      |=> bulk_current_addr == {$past(reg_wdata[31:4]), 4'h0}) else $error("bulk current sw write lost");
   cur_ctl_write_a:
   assert property (ctl_bulk_current_we |=> bulk_current_addr == {$past(ctl_bulk_current_wdata[31:4]), 4'h0})
      else $error("bulk current ctl write lost");
   done_ctl_write_a:
   assert property (ctl_done_queue_we |=> done_queue_addr == {$past(ctl_done_queue_wdata[31:4]), 4'h0})
      else $error("done queue ctl write lost");
   done_sw_ro_a:
   assert property (!ctl_done_queue_we |=> $stable(done_queue_addr))
      else $error("done queue changed without ctl write");
   done_read_a:
   assert property (reg_read && reg_addr == 8'h30 |=> reg_rdata == $past(done_queue_addr))
      else $error("done queue read wrong");
   ptr_low_zero_a:
   assert property ((bulk_head_addr[3:0] | bulk_current_addr[3:0] | done_queue_addr[3:0]) == 4'h0)
      else $error("pointer low bits set");
   toggle_flip_a:
   assert property (wr_frame |=> interval_toggle != $past(interval_toggle) && frame_interval_loaded)
      else $error("toggle did not invert");
   frame_fields_a:
   assert property (wr_frame |=> frame_length_bits == $past(reg_wdata[13:0])
      && max_packet_bits == $past(reg_wdata[30:16])) else $error("frame fields wrong");
   cover property (wr_frame);
   cover property (ctl_bulk_current_we && reg_write && reg_addr == 8'h2c);
   cover property (reg_read && reg_addr == 8'h30);
endmodule

bind uhlp_list_regs uhlp_list_regs_checker i_chk (.*);

`default_nettype wire

// file: verif/uhlp_list_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module uhlp_list_regs_tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  reg_addr = 8'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_write = 1'b0;
   logic        reg_read = 1'b0;
   logic        ctl_bulk_current_we = 1'b0;
   logic [31:0] ctl_bulk_current_wdata = 32'h0;
   logic        ctl_done_queue_we = 1'b0;
   logic [31:0] ctl_done_queue_wdata = 32'h0;
   wire  [31:0] reg_rdata;
   wire  [31:0] bulk_head_addr;
   wire  [31:0] bulk_current_addr;
   wire  [31:0] done_queue_addr;
   wire  [13:0] frame_length_bits;
   wire  [14:0] max_packet_bits;
   wire         interval_toggle;
   wire         frame_interval_loaded;
   int          num_errors = 0;
   int          checks_done = 0;
   // address, write data, read-back value
   logic [71:0] rows [0:5] = '{
      {8'h28, 32'hffff_ffff, 32'hffff_fff0},
      {8'h2c, 32'h1234_567f, 32'h1234_5670},
      {8'h30, 32'hffff_ffff, 32'h0000_0000},
      {8'h34, 32'h7fff_3fff, 32'hffff_3fff},
      {8'h34, 32'h0000_0000, 32'h0000_0000},
      {8'h3c, 32'h5555_5555, 32'h0000_0000}};

   always #2 clk = ~clk;

   uhlp_list_regs i_dut (.*);

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask

   task automatic complete_run();
      if (num_errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      #1 check(bulk_head_addr | bulk_current_addr | done_queue_addr, 32'h0);
      check({interval_toggle, max_packet_bits, 2'h0, frame_length_bits}, 32'h0000_2ebf);
      rd(8'h34, 32'h0000_2ebf);
      foreach (rows[i]) begin
         wr(rows[i][71:64], rows[i][63:32]);
         rd(rows[i][71:64], rows[i][31:0]);
      end
      // access status: done-queue write and unmapped access both flagged, write one clears
      rd(8'h40, 32'h0000_0003);
      wr(8'h40, 32'h0000_0001);
      rd(8'h40, 32'h0000_0002);
      @(posedge clk);
      #1 check(reg_rdata, 32'h0000_0000);
      ctl_done_queue_wdata <= 32'hdead_beef;
      ctl_done_queue_we <= 1'b1;
      @(posedge clk);
      ctl_done_queue_we <= 1'b0;
      #1 check(done_queue_addr, 32'hdead_bee0);
      wr(8'h30, 32'h0);
      rd(8'h30, 32'hdead_bee0);
      // controller and software hit bulk current together
      ctl_bulk_current_wdata <= 32'h2222_2229;
      ctl_bulk_current_we <= 1'b1;
      wr(8'h2c, 32'h1111_1110);
      ctl_bulk_current_we <= 1'b0;
      #1 check(bulk_current_addr, 32'h2222_2220);
      wr(8'h34, 32'h8123_0456);
      #1 check({1'b0, interval_toggle, frame_interval_loaded, max_packet_bits, frame_length_bits},
               {1'b0, 1'b1, 1'b1, 15'h0123, 14'h0456});
      @(posedge clk);
      #1 check({31'h0, frame_interval_loaded}, 32'h0);
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      #1 check(bulk_head_addr | bulk_current_addr | done_queue_addr, 32'h0);
      check({interval_toggle, max_packet_bits, 2'h0, frame_length_bits}, 32'h0000_2ebf);
      @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      complete_run();
   end

   initial begin
      #4000;
      num_errors++;
      complete_run();
   end
endmodule

`default_nettype wire
